// ==== msb_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the mode/reset block.
`ifndef MSB_DEFINES_SVH
`define MSB_DEFINES_SVH
`define MSB_OFF_MODE 8'h00
`define MSB_OFF_SRST 8'h02
`define MSB_OFF_CTRL 8'h04
`define MSB_OFF_IRQ_STAT 8'h06
`define MSB_OFF_IRQ_MASK 8'h08
`define MSB_OFF_FILL_STAT 8'h0a
`define MSB_MODE_RST 16'h0000
`define MSB_SRST_RST 16'h0000
`define MSB_MODE_MASK 16'h01ff
`define MSB_SRST_MASK 16'h0003
`define MSB_B_START 0
`define MSB_B_PAT_LO 1
`define MSB_B_PAT_HI 3
`define MSB_B_TXEN 4
`define MSB_B_RXEN 5
`define MSB_B_BDL 6
`define MSB_B_BDH 7
`define MSB_B_PDEN 8
`define MSB_B_PLLRST 0
`define MSB_B_SWRST 1
`define MSB_B_FILLEN 0
`define MSB_EV_DONE 0
`define MSB_EV_ABORT 1
`define MSB_FRAME_NS 125000
`define MSB_CLK_NS 8
`define MSB_FILL_FRAMES 2
`define MSB_CM_AW 12
`define MSB_CM_LAST 12'hfff
`define MSB_IRQ_MASK_BITS 16'h0003
`define MSB_STREAMS 32
`define MSB_HALF_STREAMS 16
`endif

// ==== msb_pkg.sv ====
// Types shared by the mode/reset block files.
package msb_pkg;
  typedef enum logic [1:0] {
    MSB_IDLE = 2'b00,
    MSB_FILL = 2'b01,
    MSB_WAIT = 2'b10
  } msb_fill_e;
  typedef logic [15:0] msb_word_t;
endpackage

// ==== msb_frame_tick.sv ====
// Frame timing divider: one-cycle pulse per frame.
`timescale 1ns/1ps
`default_nettype none
`include "msb_defines.svh"
module msb_frame_tick #(
  parameter int unsigned FRAME_CYC = `MSB_FRAME_NS / `MSB_CLK_NS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic clr,
  output logic tick
);
  logic [31:0] cnt_r;

  // Counter restarts on clr so frames are counted from the fill start.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 32'h0;
    end else if (clr || cnt_r == FRAME_CYC - 1) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  assign tick = !clr && (cnt_r == FRAME_CYC - 1);
endmodule
`default_nettype wire

// ==== msb_top.sv ====
// Mode selection and software reset register bank with connection-memory block fill.
// Register map, 16-bit words at even byte offsets:
//   0x00 mode select: bit 0 fill start, bits 3:1 fill pattern,
//        bit 4 error transmit enable, bit 5 error receive enable,
//        bit 6 lower half bidir, bit 7 upper half bidir,
//        bit 8 serial pull-down enable.
//   0x02 soft reset: bit 0 PLL reset, bit 1 switch reset.
//   0x04 control: bit 0 fill mode enable.
//   0x06 event status, write one to clear: bit 0 fill done,
//        bit 1 fill aborted.
//   0x08 event mask, same layout as the event status word.
//   0x0a fill state, read only: 0 idle, 1 sweeping, 2 waiting.
// Reserved bits are not stored and always read back as zero.
// Unmapped offsets read zero and ignore writes.
//
// Fill timeline: a fresh start bit with the enable already set launches
// a sweep of all 4096 words, one word per clock, and then the block waits
// for the second frame tick counted from the launch before it drops the
// start bit and flags completion.
// The memory itself is far faster than two frames, but software may rely
// on the start bit staying high for that long, so the wait is kept.
// A start bit that is already high when the enable arrives launches
// nothing; software has to write it low and then high again.
// Dropping the start bit or the enable while busy aborts at once; the
// words written so far stay in the memory, so a partial fill is possible.
// The pattern is read live from the mode word during the sweep, which is
// why software must leave that word alone while the start bit is high.
//
// Soft resets are plain levels with no self-clear; the PLL and the
// switching blocks stay held for as long as their bit reads one.
// Per-stream gating is combinational so that a mode change takes
// effect in the cycle after the write.
// The interrupt is a level: high while any unmasked event bit is set.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "msb_defines.svh"
module msb_top (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire msb_pkg::msb_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output msb_pkg::msb_word_t reg_rdata,
  input wire logic [31:0] serial_in,
  output logic [31:0] serial_in_eff,
  input wire logic [31:0] serial_bidir_in,
  output logic [31:0] stream_in_sel_bidir,
  output logic upper_half_bidir,
  output logic lower_half_bidir,
  output logic serial_pd_en,
  input wire logic [31:0] err_rx_enable_ch,
  input wire logic [31:0] err_tx_enable_ch,
  output logic [31:0] err_rx_active,
  output logic [31:0] err_tx_active,
  output logic pll_soft_reset,
  output logic switch_soft_reset,
  output logic cm_wr,
  output logic [`MSB_CM_AW-1:0] cm_addr,
  output msb_pkg::msb_word_t cm_low_data,
  output msb_pkg::msb_word_t cm_high_data,
  output logic irq
);
  import msb_pkg::*;

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  msb_word_t mode_r, srst_r, irq_stat_r, irq_mask_r;
  logic fill_mode_enable_r;
  msb_fill_e state_r, state_nxt;
  logic [`MSB_CM_AW-1:0] addr_r;
  logic [1:0] frames_r;
  logic tick;

  wire hit_mode = reg_addr == `MSB_OFF_MODE;
  wire hit_srst = reg_addr == `MSB_OFF_SRST;
  wire hit_ctrl = reg_addr == `MSB_OFF_CTRL;
  wire hit_stat = reg_addr == `MSB_OFF_IRQ_STAT;
  wire hit_mask = reg_addr == `MSB_OFF_IRQ_MASK;
  wire hit_fst = reg_addr == `MSB_OFF_FILL_STAT;
  // Write strobes, one per register, so each register process is a single test.
  wire wr_mode = reg_wr && hit_mode;
  wire wr_srst = reg_wr && hit_srst;
  wire wr_ctrl = reg_wr && hit_ctrl;
  wire wr_stat = reg_wr && hit_stat;
  wire wr_mask = reg_wr && hit_mask;

  // Next values of the software registers; reserved bits are masked off
  // here so they can never be stored, whatever software writes.
  wire [15:0] mode_nxt = reg_wdata & `MSB_MODE_MASK;
  wire [15:0] srst_nxt = reg_wdata & `MSB_SRST_MASK;
  wire [15:0] mask_nxt = reg_wdata & `MSB_IRQ_MASK_BITS;

  // Fields of the mode word that the sequencer reads.
  logic start_was_r;
  wire start_bit = mode_r[`MSB_B_START];
  wire [2:0] fill_pattern = mode_r[`MSB_B_PAT_HI:`MSB_B_PAT_LO];

  // ----------------------------------------------------------------
  // Fill sequencer
  // ----------------------------------------------------------------
  // Abort when start or enable falls while a fill is under way.
  wire busy = state_r != MSB_IDLE;
  wire abort = busy && (!start_bit || !fill_mode_enable_r);
  wire last_word = addr_r == `MSB_CM_LAST;
  // The second frame tick after launch ends the wait; the first one only counts.
  wire last_frame = frames_r == 2'(`MSB_FILL_FRAMES - 1);
  wire finish = busy && !abort && state_r == MSB_WAIT && tick && last_frame;
  // Launch needs both bits and a start level that was low before.
  wire go = state_r == MSB_IDLE && start_bit && fill_mode_enable_r && !start_was_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MSB_IDLE: begin
        if (go) begin
          state_nxt = MSB_FILL;
        end
      end
      MSB_FILL: begin
        if (abort) begin
          state_nxt = MSB_IDLE;
        end else if (last_word) begin
          state_nxt = MSB_WAIT;
        end
      end
      MSB_WAIT: begin
        if (abort || finish) begin
          state_nxt = MSB_IDLE;
        end
      end
      default: begin
        state_nxt = MSB_IDLE;
      end
    endcase
  end

  // Frame divider, restarted by the launch so that the two frames are
  // counted from the moment the fill begins.
  msb_frame_tick u_tick (
    .clk(clk),
    .rstn(rstn),
    .clr(go),
    .tick(tick)
  );

  // Fill completion is paced to the frame so the result matches the
  // two-frame figure; the memory sweep itself ends far earlier.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= MSB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Sweep address; it returns to zero outside the sweep so that every
  // launch starts at the first word, even after an abort.
  wire [`MSB_CM_AW-1:0] addr_nxt = (state_r == MSB_FILL && !abort) ? addr_r + 1'b1 : '0;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_r <= '0;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // Frame count since launch; the launch itself clears it.
  wire [1:0] frames_nxt = go ? 2'd0 : ((tick && busy) ? frames_r + 2'd1 : frames_r);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frames_r <= 2'd0;
    end else begin
      frames_r <= frames_nxt;
    end
  end

  // Level of start last cycle, so only a fresh 0 to 1 starts a fill.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_was_r <= 1'b0;
    end else begin
      start_was_r <= start_bit && !go && state_r == MSB_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Connection memory write port
  // ----------------------------------------------------------------
  // Strobe and address are registered together so the memory sees a
  // matching pair; no word goes out in the cycle in which an abort appears.
  wire sweep_wr = state_r == MSB_FILL && !abort;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cm_wr <= 1'b0;
      cm_addr <= '0;
    end else begin
      cm_wr <= sweep_wr;
      cm_addr <= addr_r;
    end
  end

  // Data words are constant over a sweep; only the pattern field is live.
  wire [15:0] low_word = {13'h0, fill_pattern};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cm_low_data <= 16'h0000;
      cm_high_data <= 16'h0000;
    end else begin
      cm_low_data <= low_word;
      cm_high_data <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Hardware clear of start on completion; a write in the same cycle
  // wins since software asked for a new fill.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_r <= `MSB_MODE_RST;
    end else if (wr_mode) begin
      mode_r <= mode_nxt;
    end else if (finish) begin
      mode_r[`MSB_B_START] <= 1'b0;
    end
  end

  // Soft reset levels go straight to the PLL and the switch; there is no
  // self-clear, so software must write the bit low to release the block.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      srst_r <= `MSB_SRST_RST;
    end else if (wr_srst) begin
      srst_r <= srst_nxt;
    end
  end

  // Fill mode enable; dropping it during a fill aborts the fill.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fill_mode_enable_r <= 1'b0;
    end else if (wr_ctrl) begin
      fill_mode_enable_r <= reg_wdata[`MSB_B_FILLEN];
    end
  end

  // Event mask, same layout as the status word.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_r <= 16'h0000;
    end else if (wr_mask) begin
      irq_mask_r <= mask_nxt;
    end
  end

  // Sticky events: set wins over a write-one clear, so an event that
  // lands in the clearing cycle is never lost.
  wire [15:0] ev = {14'h0000, abort, finish};
  wire [15:0] stat_clr = wr_stat ? reg_wdata : 16'h0000;
  wire [15:0] stat_nxt = (irq_stat_r & ~stat_clr) | ev;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= 16'h0000;
    end else begin
      irq_stat_r <= stat_nxt;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // Read mux; unmapped addresses read zero, data one cycle later.
  // Reads have no side effects, so polling the start bit is harmless.
  wire [15:0] ctrl_word = {15'h0000, fill_mode_enable_r};
  wire [15:0] fst_word = {14'h0000, state_r};
  wire [15:0] rd_mux = hit_mode ? mode_r :
                       hit_srst ? srst_r :
                       hit_ctrl ? ctrl_word :
                       hit_stat ? irq_stat_r :
                       hit_mask ? irq_mask_r :
                       hit_fst ? fst_word : 16'h0000;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Mode outputs and stream steering
  // ----------------------------------------------------------------
  assign upper_half_bidir = mode_r[`MSB_B_BDH];
  assign lower_half_bidir = mode_r[`MSB_B_BDL];
  assign serial_pd_en = mode_r[`MSB_B_PDEN];
  assign pll_soft_reset = srst_r[`MSB_B_PLLRST];
  assign switch_soft_reset = srst_r[`MSB_B_SWRST];

  // In bidir mode the shared pin feeds the switch in place of the dedicated input.
  // Per-stream results are gathered on nets first and handed to the ports
  // whole, so each output has exactly one continuous driver.
  wire [31:0] bd_vec;
  wire [31:0] in_eff_vec;
  wire [31:0] rx_act_vec;
  wire [31:0] tx_act_vec;
  genvar i;
  generate
    for (i = 0; i < `MSB_STREAMS; i++) begin : g_strm
      wire bd = (i >= `MSB_HALF_STREAMS) ? upper_half_bidir : lower_half_bidir;
      assign bd_vec[i] = bd;
      assign in_eff_vec[i] = bd ? serial_bidir_in[i] : serial_in[i];
      assign rx_act_vec[i] = err_rx_enable_ch[i] && mode_r[`MSB_B_RXEN];
      assign tx_act_vec[i] = err_tx_enable_ch[i] && mode_r[`MSB_B_TXEN];
    end
  endgenerate

  // Port hand-off of the per-stream results.
  assign stream_in_sel_bidir = bd_vec;
  assign serial_in_eff = in_eff_vec;
  assign err_rx_active = rx_act_vec;
  assign err_tx_active = tx_act_vec;
endmodule
`default_nettype wire

// ==== msb_top_assertions.sv ====
// Concurrent checks on the ports of the mode and reset block.
`timescale 1ns/1ps
`default_nettype none
module msb_chk (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire msb_pkg::msb_word_t reg_wdata,
  input wire logic reg_wr,
  input wire logic [31:0] serial_in,
  input wire logic [31:0] serial_in_eff,
  input wire logic [31:0] serial_bidir_in,
  input wire logic upper_half_bidir,
  input wire logic lower_half_bidir,
  input wire logic [31:0] err_rx_enable_ch,
  input wire logic [31:0] err_tx_enable_ch,
  input wire logic [31:0] err_rx_active,
  input wire logic [31:0] err_tx_active,
  input wire logic pll_soft_reset,
  input wire logic switch_soft_reset,
  input wire logic cm_wr,
  input wire logic [11:0] cm_addr,
  input wire msb_pkg::msb_word_t cm_low_data,
  input wire msb_pkg::msb_word_t cm_high_data
);
  import msb_pkg::*;
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // A mode write and two fill words in a row are the steps checked below.
  sequence s_mode_wr;
    reg_wr && reg_addr == 8'h00;
  endsequence
  sequence s_two_words;
    cm_wr ##1 cm_wr;
  endsequence
  hi_bidir_sel_a: assert property (serial_in_eff[31:16] ==
    (upper_half_bidir ? serial_bidir_in[31:16] : serial_in[31:16])) else $error("upper sel");
  lo_bidir_sel_a: assert property (serial_in_eff[15:0] ==
    (lower_half_bidir ? serial_bidir_in[15:0] : serial_in[15:0])) else $error("lower sel");
  rx_gate_a: assert property (s_mode_wr |=>
    err_rx_active == (err_rx_enable_ch & {32{$past(reg_wdata[5])}})) else $error("rx gate");
  tx_gate_a: assert property (s_mode_wr |=>
    err_tx_active == (err_tx_enable_ch & {32{$past(reg_wdata[4])}})) else $error("tx gate");
  fill_zero_a: assert property (cm_wr |->
    cm_low_data[15:3] == 13'h0 && cm_high_data == 16'h0) else $error("fill upper bits");
  fill_step_a: assert property (s_two_words |->
    $stable(cm_low_data) && cm_addr == $past(cm_addr) + 12'h1) else $error("fill step");
  pll_rst_a: assert property (reg_wr && reg_addr == 8'h02 |=>
    pll_soft_reset == $past(reg_wdata[0])) else $error("pll reset");
  sw_rst_a: assert property (reg_wr && reg_addr == 8'h02 |=>
    switch_soft_reset == $past(reg_wdata[1])) else $error("switch reset");
  abort_stop_a: assert property (reg_wr && reg_addr == 8'h04 && !reg_wdata[0] |->
    ##4 !cm_wr) else $error("abort");
endmodule
bind msb_top msb_chk u_chk (.*);
`default_nettype wire

// ==== mode_select_block_program_reset_bench.sv ====
// Self-checking bench for the mode and reset block.
`timescale 1ns/1ps
`default_nettype none
module mode_select_block_program_reset_bench;
  import msb_pkg::*;
  logic clk, rstn, reg_wr, reg_rd, cm_wr, irq, upper_half_bidir, lower_half_bidir;
  logic serial_pd_en, pll_soft_reset, switch_soft_reset;
  logic [7:0] reg_addr;
  logic [11:0] cm_addr;
  msb_word_t reg_wdata, reg_rdata, cm_low_data, cm_high_data, d, pat;
  logic [31:0] serial_in, serial_in_eff, serial_bidir_in, stream_in_sel_bidir;
  logic [31:0] err_rx_enable_ch, err_tx_enable_ch, err_rx_active, err_tx_active;
  int err_total, n_tests, cyc, n_wr, bad_wr, t0;
  // Rows: offset, written value, value read back.
  msb_word_t rows [5][3] = '{'{16'h00, 16'hfffe, 16'h01fe}, '{16'h02, 16'hffff, 16'h0003},
    '{16'h0e, 16'hffff, 16'h0000}, '{16'h08, 16'h0003, 16'h0003}, '{16'h02, 16'h0, 16'h0}};
  msb_top DUT (.*);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input msb_word_t v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Starts a fill, then clears one of the two bits; no word may follow the abort.
  task automatic abort_run(input logic [7:0] a);
    int k;
    wr(8'h00, 16'h000b);
    repeat (10) @(posedge clk);
    rd(8'h0a);
    cmp(d, 16'h1);
    wr(a, 16'h0);
    repeat (8) @(posedge clk);
    k = n_wr;
    repeat (20) @(posedge clk);
    cmp(n_wr == k && k > 0, 1);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, word monitor and time limit
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // The limit covers two frames of fill plus margin, so a hung fill still ends the run.
  always @(posedge clk) begin
    cyc++;
    if (cm_wr === 1'b1) begin
      n_wr++;
      if (cm_low_data !== pat || cm_high_data !== 16'h0) bad_wr++;
    end
    if (cyc == 60000) begin
      err_total++;
      give_verdict;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, pat} = '0;
    serial_in = 32'haaaa5555;
    serial_bidir_in = 32'h1234abcd;
    err_rx_enable_ch = 32'hffffffff;
    err_tx_enable_ch = 32'h0f0f0f0f;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h02);
    cmp(d, 16'h0);
    cmp({pll_soft_reset, switch_soft_reset, irq, cm_wr}, 0);
    $display("reset test done");
    for (int i = 0; i < 5; i++) begin
      wr(rows[i][0][7:0], rows[i][1]);
      rd(rows[i][0][7:0]);
      cmp(d, rows[i][2]);
    end
    cmp(serial_in_eff, serial_bidir_in);
    cmp(stream_in_sel_bidir, 32'hffffffff);
    cmp({serial_pd_en, upper_half_bidir, lower_half_bidir}, 3'b111);
    cmp(err_rx_active, err_rx_enable_ch);
    cmp(err_tx_active, err_tx_enable_ch);
    wr(8'h02, 16'h0003);
    cmp({pll_soft_reset, switch_soft_reset}, 2'b11);
    wr(8'h02, 16'h0000);
    cmp({pll_soft_reset, switch_soft_reset}, 2'b00);
    wr(8'h00, 16'h0040);
    cmp(serial_in_eff, {serial_in[31:16], serial_bidir_in[15:0]});
    cmp(stream_in_sel_bidir, 32'h0000ffff);
    cmp({upper_half_bidir, lower_half_bidir}, 2'b01);
    cmp(err_rx_active | err_tx_active, 0);
    $display("register and mode test done");
    pat = 16'h0005;
    wr(8'h00, 16'h000b);
    repeat (20) @(posedge clk);
    cmp(n_wr, 0);
    wr(8'h00, 16'h0);
    wr(8'h04, 16'h1);
    rd(8'h04);
    cmp(d, 16'h1);
    wr(8'h08, 16'h1);
    t0 = cyc;
    wr(8'h00, 16'h000b);
    d = 16'h1;
    for (int k = 0; k < 20000 && d[0]; k++) rd(8'h00);
    cmp(d, 16'h000a);
    cmp(cyc - t0 > 31000 && cyc - t0 < 31400, 1);
    cmp(n_wr, 4096);
    cmp(irq, 1);
    rd(8'h06);
    cmp(d, 16'h1);
    wr(8'h06, 16'h1);
    cmp(irq, 0);
    $display("fill test done");
    abort_run(8'h04);
    cmp(irq, 0);
    rd(8'h06);
    cmp(d, 16'h2);
    wr(8'h08, 16'h3);
    cmp(irq, 1);
    wr(8'h00, 16'h0);
    wr(8'h04, 16'h1);
    abort_run(8'h00);
    cmp(bad_wr, 0);
    $display("abort test done");
    give_verdict;
  end
endmodule
`default_nettype wire
